// ### rtl/idfcn_pkg.sv
// Purpose: Shared constants and types of the isolated I/O register bank.
// Assumes: 8-bit registers on a local port behind the bus bridge.
// Notes: Offsets are byte offsets from the board's base address.
package idfcn_pkg;

   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int PORT_W = 8;
   localparam int LINES = 24;
   localparam int IVL_W = 20;

   // Register offsets.
   localparam logic [ADDR_W-1:0] OFF_IN0 = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_IN1 = 6'h01;
   localparam logic [ADDR_W-1:0] OFF_IN2 = 6'h02;
   localparam logic [ADDR_W-1:0] OFF_OUT3 = 6'h03;
   localparam logic [ADDR_W-1:0] OFF_OUT4 = 6'h04;
   localparam logic [ADDR_W-1:0] OFF_OUT5 = 6'h05;
   localparam logic [ADDR_W-1:0] OFF_ID = 6'h06;
   localparam logic [ADDR_W-1:0] OFF_CLEAR = 6'h07;
   localparam logic [ADDR_W-1:0] OFF_IVL0 = 6'h08;
   localparam logic [ADDR_W-1:0] OFF_IVL1 = 6'h09;
   localparam logic [ADDR_W-1:0] OFF_IVL2 = 6'h0A;
   localparam logic [ADDR_W-1:0] OFF_FEN0 = 6'h0C;
   localparam logic [ADDR_W-1:0] OFF_FEN1 = 6'h0D;
   localparam logic [ADDR_W-1:0] OFF_FEN2 = 6'h0E;
   localparam logic [ADDR_W-1:0] OFF_STAT = 6'h14;
   localparam logic [ADDR_W-1:0] OFF_IRQC = 6'h15;
   localparam logic [ADDR_W-1:0] OFF_RISE0 = 6'h18;
   localparam logic [ADDR_W-1:0] OFF_RISE1 = 6'h19;
   localparam logic [ADDR_W-1:0] OFF_RISE2 = 6'h1A;
   localparam logic [ADDR_W-1:0] OFF_FALL0 = 6'h20;
   localparam logic [ADDR_W-1:0] OFF_FALL1 = 6'h21;
   localparam logic [ADDR_W-1:0] OFF_FALL2 = 6'h22;

   // Clear register bits.
   localparam int CLR_RELOAD_BIT = 0;
   localparam int CLR_FILTER_BIT = 1;
   localparam int CLR_OVERRUN_BIT = 2;
   localparam int CLR_EDGE_BIT = 3;

   // Status register bits.
   localparam int ST_EDGE_BIT = 0;
   localparam int ST_OVERRUN_BIT = 1;
   localparam int ST_IRQ_BIT = 2;

   // Interrupt control bits.
   localparam int IC_EDGE_EN_BIT = 0;
   localparam int IC_OVR_EN_BIT = 1;
   localparam int IC_MASTER_EN_BIT = 2;
   localparam int IC_RISE_EN_BIT = 3;
   localparam int IC_FALL_EN_BIT = 4;
   localparam int IC_USED_W = 5;

   // Reset values.
   localparam logic [LINES-1:0] RELAY_RESET = 24'hFFFFFF;
   localparam logic [DATA_W-1:0] IRQC_RESET = 8'h18;
   localparam logic [DATA_W-1:0] ID_CODE = 8'hA5; // Arbitrary value.
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

   // Timing of the filter interval unit.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int IVL_UNIT_NS = 200;
   localparam int UNIT_CYC = (IVL_UNIT_NS * 1000) / CLK_PERIOD_PS;
   localparam int UNIT_W = $clog2(UNIT_CYC);

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } idfcn_req_t;

endpackage

// ### rtl/idfcn_dio.sv
// Purpose: Isolated 24-in/24-relay I/O bank with glitch filter and edge irq.
// Assumes: The bus bridge turns host accesses into one-cycle strobes.
// Notes: Relay lines are 1 for open, 0 for closed.
// Behaviour
// - Inputs readable at offsets 00, 01, 02.
// - Relay registers at 03, 04, 05 drive relays.
// - Relay register reads return last written value.
// - Fixed identity code readable at offset 06.
// - Clear register at 07 resets selected functions.
// - Each of 24 lines has own filter enable.
// - One shared interval at 08..0A governs filters.
// - Filter enable registers at 0C, 0D, 0E.
// - Edges raise interrupt, rising/falling masked separately.
// - Rising masks at 18, 19, 1A.
// - Falling masks at 20, 21, 22.
// - Interrupt control at 15, status at 14.
// - Filtered lines feed the edge detectors.
// - Offsets are relative to host base address.
// - Bit 7 is MSB, bit 0 LSB.
// - Relay registers reset to FF, relays open.
// - Interval is 20 bits of 200 ns.
// - Clear bits: edge, overflow (only together with edge), filter, interval reload.
// - Status: edge seen, overrun, interrupt asserted.
`timescale 1ns/10ps
module idfcn_dio
#(
   parameter int LINES = idfcn_pkg::LINES
)
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Register port from the bus bridge, offset from base address.
   input wire idfcn_pkg::idfcn_req_t i_req,
   output logic [idfcn_pkg::DATA_W-1:0] o_rd_data,
   output logic o_rd_valid,
   // Field lines.
   input wire logic [LINES-1:0] i_opto_in,
   output logic [LINES-1:0] o_solid_state_relay,
   // Change notification interrupt.
   output logic o_irq
);

   localparam int PW = idfcn_pkg::PORT_W;
   localparam int IW = idfcn_pkg::IVL_W;
   localparam logic [idfcn_pkg::UNIT_W-1:0] UNIT_LAST =
      idfcn_pkg::UNIT_W'(idfcn_pkg::UNIT_CYC - 1);

   logic [LINES-1:0] sync1_r;
   logic [LINES-1:0] sync2_r;
   logic [LINES-1:0] filt_r;
   logic [LINES-1:0] cand_r;
   logic [LINES-1:0] moved_r;
   logic [LINES-1:0] prev_r;
   logic [LINES-1:0] relay_r;
   logic [LINES-1:0] fen_r;
   logic [LINES-1:0] rise_r;
   logic [LINES-1:0] fall_r;
   logic [IW-1:0] ivl_r;
   logic [IW-1:0] ivl_cnt_r;
   logic [idfcn_pkg::UNIT_W-1:0] unit_cnt_r;
   logic [idfcn_pkg::DATA_W-1:0] irqc_r;
   logic edge_r;
   logic ovr_r;
   logic irq_r;
   logic filt_tick;
   logic unit_tick;
   logic [LINES-1:0] ev_rise;
   logic [LINES-1:0] ev_fall;
   logic any_ev;
   logic clr_wr;
   logic do_reload;
   logic do_filt_clr;
   logic do_edge_clr;
   logic do_ovr_clr;
   logic irq_nxt;
   logic [idfcn_pkg::DATA_W-1:0] rd_nxt;

   // Two-flop synchroniser for the field inputs.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= i_opto_in;
         sync2_r <= sync1_r;
      end
   end

   // Clear register decode.
   assign clr_wr = i_req.wr && (i_req.addr == idfcn_pkg::OFF_CLEAR);
   assign do_reload = clr_wr && i_req.wdata[idfcn_pkg::CLR_RELOAD_BIT];
   assign do_filt_clr = clr_wr && i_req.wdata[idfcn_pkg::CLR_FILTER_BIT];
   assign do_edge_clr = clr_wr && i_req.wdata[idfcn_pkg::CLR_EDGE_BIT];
   assign do_ovr_clr = do_edge_clr &&
      i_req.wdata[idfcn_pkg::CLR_OVERRUN_BIT];

   // Register writes; offsets are relative to the base address.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         relay_r <= idfcn_pkg::RELAY_RESET;
         fen_r <= '0;
         rise_r <= '0;
         fall_r <= '0;
         ivl_r <= '0;
         irqc_r <= idfcn_pkg::IRQC_RESET;
      end
      else if (i_req.wr)
      begin
         unique case (i_req.addr)
            idfcn_pkg::OFF_OUT3: relay_r[0*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_OUT4: relay_r[1*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_OUT5: relay_r[2*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_IVL0: ivl_r[7:0] <= i_req.wdata;
            idfcn_pkg::OFF_IVL1: ivl_r[15:8] <= i_req.wdata;
            idfcn_pkg::OFF_IVL2: ivl_r[IW-1:16] <= i_req.wdata[IW-17:0];
            idfcn_pkg::OFF_FEN0: fen_r[0*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_FEN1: fen_r[1*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_FEN2: fen_r[2*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_IRQC: irqc_r <= {3'h0,
               i_req.wdata[idfcn_pkg::IC_USED_W-1:0]};
            idfcn_pkg::OFF_RISE0: rise_r[0*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_RISE1: rise_r[1*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_RISE2: rise_r[2*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_FALL0: fall_r[0*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_FALL1: fall_r[1*PW +: PW] <= i_req.wdata;
            idfcn_pkg::OFF_FALL2: fall_r[2*PW +: PW] <= i_req.wdata;
            default: ;
         endcase
      end
   end

   assign o_solid_state_relay = relay_r;

   // Interval timer: 200 ns units counted down from the shared interval.
   assign unit_tick = (unit_cnt_r == UNIT_LAST);
   assign filt_tick = unit_tick && (ivl_cnt_r == '0);

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         unit_cnt_r <= '0;
         ivl_cnt_r <= '0;
      end
      else if (do_reload)
      begin
         unit_cnt_r <= '0;
         ivl_cnt_r <= ivl_r;
      end
      else if (unit_tick)
      begin
         unit_cnt_r <= '0;
         ivl_cnt_r <= (ivl_cnt_r == '0) ? ivl_r : ivl_cnt_r - 1'b1;
      end
      else
      begin
         unit_cnt_r <= unit_cnt_r + 1'b1;
      end
   end

   // Glitch filter: a level is taken only if it held a full interval.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst || do_filt_clr)
      begin
         filt_r <= sync2_r;
         cand_r <= sync2_r;
         moved_r <= '0;
      end
      else
      begin
         for (int i = 0; i < LINES; i++)
         begin
            if (!fen_r[i])
            begin
               filt_r[i] <= sync2_r[i];
               cand_r[i] <= sync2_r[i];
               moved_r[i] <= 1'b0;
            end
            else if (filt_tick)
            begin
               if (!moved_r[i] && (sync2_r[i] == cand_r[i]))
               begin
                  filt_r[i] <= cand_r[i];
               end
               cand_r[i] <= sync2_r[i];
               moved_r[i] <= 1'b0;
            end
            else if (sync2_r[i] != cand_r[i])
            begin
               moved_r[i] <= 1'b1;
            end
         end
      end
   end

   // Edge detection on filtered lines.
   assign ev_rise = filt_r & ~prev_r & rise_r &
      {LINES{irqc_r[idfcn_pkg::IC_RISE_EN_BIT]}};
   assign ev_fall = ~filt_r & prev_r & fall_r &
      {LINES{irqc_r[idfcn_pkg::IC_FALL_EN_BIT]}};
   assign any_ev = |(ev_rise | ev_fall);

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst || do_edge_clr)
      begin
         prev_r <= filt_r;
      end
      else
      begin
         prev_r <= filt_r;
      end
   end

   // Sticky flags; a new edge wins over a clear in the same cycle.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         edge_r <= 1'b0;
         ovr_r <= 1'b0;
      end
      else
      begin
         edge_r <= any_ev || (edge_r && !do_edge_clr);
         ovr_r <= (any_ev && irq_r) || (ovr_r && !do_ovr_clr);
      end
   end

   assign irq_nxt = irqc_r[idfcn_pkg::IC_MASTER_EN_BIT] &&
      ((irqc_r[idfcn_pkg::IC_EDGE_EN_BIT] && edge_r) ||
       (irqc_r[idfcn_pkg::IC_OVR_EN_BIT] && ovr_r));

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= irq_nxt;
      end
   end

   assign o_irq = irq_r;

   // Read multiplexer; unmapped and write-only offsets read as zero.
   always_comb
   begin
      rd_nxt = idfcn_pkg::ZERO_BYTE;
      unique case (i_req.addr)
         idfcn_pkg::OFF_IN0: rd_nxt = filt_r[0*PW +: PW];
         idfcn_pkg::OFF_IN1: rd_nxt = filt_r[1*PW +: PW];
         idfcn_pkg::OFF_IN2: rd_nxt = filt_r[2*PW +: PW];
         idfcn_pkg::OFF_OUT3: rd_nxt = relay_r[0*PW +: PW];
         idfcn_pkg::OFF_OUT4: rd_nxt = relay_r[1*PW +: PW];
         idfcn_pkg::OFF_OUT5: rd_nxt = relay_r[2*PW +: PW];
         idfcn_pkg::OFF_ID: rd_nxt = idfcn_pkg::ID_CODE;
         idfcn_pkg::OFF_IVL0: rd_nxt = ivl_r[7:0];
         idfcn_pkg::OFF_IVL1: rd_nxt = ivl_r[15:8];
         idfcn_pkg::OFF_IVL2: rd_nxt = {4'h0, ivl_r[IW-1:16]};
         idfcn_pkg::OFF_FEN0: rd_nxt = fen_r[0*PW +: PW];
         idfcn_pkg::OFF_FEN1: rd_nxt = fen_r[1*PW +: PW];
         idfcn_pkg::OFF_FEN2: rd_nxt = fen_r[2*PW +: PW];
         idfcn_pkg::OFF_STAT: rd_nxt = {5'h00, irq_r, ovr_r, edge_r};
         idfcn_pkg::OFF_IRQC: rd_nxt = irqc_r;
         idfcn_pkg::OFF_RISE0: rd_nxt = rise_r[0*PW +: PW];
         idfcn_pkg::OFF_RISE1: rd_nxt = rise_r[1*PW +: PW];
         idfcn_pkg::OFF_RISE2: rd_nxt = rise_r[2*PW +: PW];
         idfcn_pkg::OFF_FALL0: rd_nxt = fall_r[0*PW +: PW];
         idfcn_pkg::OFF_FALL1: rd_nxt = fall_r[1*PW +: PW];
         idfcn_pkg::OFF_FALL2: rd_nxt = fall_r[2*PW +: PW];
         default: rd_nxt = idfcn_pkg::ZERO_BYTE;
      endcase
   end

   // Read data is registered; bit 7 is the most significant.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         o_rd_data <= idfcn_pkg::ZERO_BYTE;
         o_rd_valid <= 1'b0;
      end
      else
      begin
         o_rd_valid <= i_req.rd;
         if (i_req.rd)
         begin
            o_rd_data <= rd_nxt;
         end
      end
   end

   property p_relay_reset;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      $past(i_sys_rst) |-> o_solid_state_relay == idfcn_pkg::RELAY_RESET;
   endproperty
   a_relay_reset: assert property (p_relay_reset)
      else $error("Relays not all open after reset.");

   property p_relay_write;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_req.wr && i_req.addr == idfcn_pkg::OFF_OUT4 |=>
         o_solid_state_relay[15:8] == $past(i_req.wdata);
   endproperty
   a_relay_write: assert property (p_relay_write)
      else $error("Relay port four did not take written value.");

   property p_relay_readback;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_req.rd && i_req.addr == idfcn_pkg::OFF_OUT5 |=>
         o_rd_valid && o_rd_data == o_solid_state_relay[23:16];
   endproperty
   a_relay_readback: assert property (p_relay_readback)
      else $error("Relay read-back differs from relay state.");

   property p_id_read;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_req.rd && i_req.addr == idfcn_pkg::OFF_ID |=>
         o_rd_data == idfcn_pkg::ID_CODE;
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("Identity read returned wrong code.");

   property p_input_read;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_req.rd && i_req.addr == idfcn_pkg::OFF_IN1 |=>
         o_rd_data == $past(filt_r[15:8]);
   endproperty
   a_input_read: assert property (p_input_read)
      else $error("Input port read wrong data.");

   property p_unfiltered_follow;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      !fen_r[0] && !do_filt_clr |=> filt_r[0] == $past(sync2_r[0]);
   endproperty
   a_unfiltered_follow: assert property (p_unfiltered_follow)
      else $error("Unfiltered line did not follow its input.");

   property p_filtered_hold;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      fen_r[0] && !filt_tick && !do_filt_clr |=> $stable(filt_r[0]);
   endproperty
   a_filtered_hold: assert property (p_filtered_hold)
      else $error("Filtered line changed between filter ticks.");

   property p_edge_sets;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      any_ev |=> edge_r ##1 (irq_r == $past(irq_nxt));
   endproperty
   a_edge_sets: assert property (p_edge_sets)
      else $error("Edge event did not set edge flag.");

   property p_overrun;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      any_ev && irq_r |=> ovr_r && edge_r;
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("Edge during interrupt did not set overrun.");

   property p_clear_edge;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      do_edge_clr && !any_ev |=> !edge_r;
   endproperty
   a_clear_edge: assert property (p_clear_edge)
      else $error("Edge clear left the edge flag set.");

   property p_reload;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      do_reload |=> ivl_cnt_r == $past(ivl_r) && unit_cnt_r == '0;
   endproperty
   a_reload: assert property (p_reload)
      else $error("Interval reload did not restart the timer.");

endmodule // idfcn_dio

// ### tb/idfcn_host.sv
// Purpose: Host model that issues register strobes to the I/O bank.
// Assumes: One strobe at a time; read answer comes within a few cycles.
// Notes: The testbench calls the tasks by hierarchical name.
`timescale 1ns/10ps
module idfcn_host
(
   // Clock.
   input wire logic i_clk_sys,
   // Register port.
   output idfcn_pkg::idfcn_req_t o_req,
   input wire logic [idfcn_pkg::DATA_W-1:0] i_rd_data,
   input wire logic i_rd_valid
);
   initial o_req = '0;

   // Offsets are given relative to the board base address.
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge i_clk_sys);
      #1;
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge i_clk_sys);
      #1;
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
   endtask

   // Released lines carry inverted values so stale data never matches.
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      int n;
      @(posedge i_clk_sys);
      #1;
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_clk_sys);
      #1;
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      n = 0;
      while (i_rd_valid !== 1'b1 && n < 4)
      begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      v = (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX;
   endtask
endmodule // idfcn_host

// ### tb/testbench.sv
// Purpose: Self-checking bench of the isolated I/O register bank.
// Assumes: Host model issues one strobe at a time.
// Notes: Expected reads come from a byte model of the register map.
`timescale 1ns/10ps
module testbench;
   logic i_clk_sys;
   logic i_sys_rst;
   idfcn_pkg::idfcn_req_t req;
   logic [7:0] rdat;
   logic rval;
   logic [23:0] opto;
   logic [23:0] relay;
   logic irq;
   logic [7:0] d;
   int bad_count;
   int comparisons;
   int cycles;
   int mdl[64];
   int p;

   idfcn_dio dut_u
   (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_req(req),
      .o_rd_data(rdat),
      .o_rd_valid(rval),
      .i_opto_in(opto),
      .o_solid_state_relay(relay),
      .o_irq(irq)
   );

   idfcn_host host_u
   (
      .i_clk_sys(i_clk_sys),
      .o_req(req),
      .i_rd_data(rdat),
      .i_rd_valid(rval)
   );

   initial
   begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end

   always @(posedge i_clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [23:0] seen,
                        input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic int wmask(input int a);
      case (a)
         6'h03, 6'h04, 6'h05, 6'h08, 6'h09, 6'h0C, 6'h0D, 6'h0E: return 8'hFF;
         6'h18, 6'h19, 6'h1A, 6'h20, 6'h21, 6'h22: return 8'hFF;
         6'h0A: return 8'h0F;
         6'h15: return 8'h1F;
         default: return 8'h00;
      endcase
   endfunction

   task automatic w(input int a, input int v);
      host_u.wr(a[5:0], v[7:0]);
      mdl[a] = (v & wmask(a)) | (mdl[a] & ~wmask(a));
   endtask

   task automatic rc(input int a, input int e);
      host_u.rd(a[5:0], d);
      check($sformatf("offset %h", a), d, e[7:0]);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic setp(input logic [23:0] v);
      @(posedge i_clk_sys);
      #1;
      opto = v;
   endtask

   task automatic irq_in(input int n, input logic e);
      int k;
      k = 0;
      while (irq !== e && k < n)
      begin
         @(posedge i_clk_sys);
         #1;
         k++;
      end
      check("irq", irq, e);
   endtask

   // Reads every offset up to 23 hex and compares with the model.
   task automatic scan();
      for (int a = 0; a < 36; a++)
         rc(a, (a < 3) ? int'(opto[8*a +: 8]) : mdl[a]);
      check("relay", relay, {mdl[5][7:0], mdl[4][7:0], mdl[3][7:0]});
   endtask

   initial
   begin
      void'($urandom(9));
      i_sys_rst = 1'b1;
      opto = $urandom;
      mdl[3] = 8'hFF;
      mdl[4] = 8'hFF;
      mdl[5] = 8'hFF;
      mdl[6] = idfcn_pkg::ID_CODE;
      mdl[6'h15] = idfcn_pkg::IRQC_RESET;
      repeat (4) @(posedge i_clk_sys);
      #1;
      i_sys_rst = 1'b0;
      // Let the input synchroniser fill before the inputs are read.
      idle(3);
      // Reset values, reserved reads and input levels.
      scan();
      irq_in(0, 1'b0);
      // Random writes to offsets 00 to 23 hex but 07 and 15, read-only places included.
      for (int a = 0; a < 36; a++)
         if (a != 7 && a != 6'h15)
            w(a, $urandom);
      w(7, 8'h02);
      idle(4);
      w(7, 8'h0C);
      w(6'h15, $urandom);
      scan();
      irq_in(0, 1'b0);
      // Edge notification on each port.
      for (p = 0; p < 3; p++)
      begin
         w(6'h0C + p, 0);
         w(6'h18 + p, 0);
         w(6'h20 + p, 0);
      end
      w(6'h15, 8'h1D);
      setp(24'h010101);
      idle(6);
      w(7, 8'h0C);
      irq_in(0, 1'b0);
      for (p = 0; p < 6; p++)
      begin
         w(((p < 3) ? 6'h18 : 6'h1D) + p, (p < 3) ? 8'h80 : 8'h01);
         setp(opto ^ (24'h000080 >> (7 * (p / 3)) << (8 * (p % 3))));
         irq_in(8, 1'b1);
         rc(6'h14, 8'h05);
         w(7, 8'h0C);
         irq_in(3, 1'b0);
         w(((p < 3) ? 6'h18 : 6'h1D) + p, 0);
      end
      // Further edge while the interrupt stands.
      w(6'h18, 8'h03);
      setp(opto | 24'h000001);
      irq_in(8, 1'b1);
      setp(opto | 24'h000002);
      idle(6);
      rc(6'h14, 8'h07);
      w(7, 8'h08);
      rc(6'h14, 8'h02);
      w(7, 8'h0C);
      rc(6'h14, 8'h00);
      // Rising class disabled in the control register.
      w(6'h15, 8'h15);
      w(6'h18, 8'h04);
      setp(opto | 24'h000004);
      idle(8);
      irq_in(0, 1'b0);
      w(6'h15, 8'h1D);
      // Glitch filter on lines 0 and 3.
      w(6'h08, 0);
      w(6'h09, 0);
      w(6'h0A, 0);
      w(6'h0C, 8'h09);
      w(7, 8'h03);
      w(6'h18, 8'h08);
      setp(opto | 24'h000008);
      idle(5);
      setp(opto & ~24'h000008);
      idle(120);
      irq_in(0, 1'b0);
      w(6'h08, 8'h01);
      w(7, 8'h01);
      setp(opto | 24'h000008);
      idle(100);
      irq_in(0, 1'b0);
      irq_in(200, 1'b1);
      wrap_up();
   end
endmodule // testbench
